// ---- cdid_pkg.sv ----
package cdid_pkg;

  // timing
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned T_SHORT_NS   = 39000;
  localparam int unsigned T_DATA_NS    = 43000;
  localparam int unsigned T_CLEAR_NS   = 1530000;
  localparam int unsigned T_BLINK_MS   = 400;
  localparam int unsigned SHORT_CYC_D  = (T_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DATA_CYC_D   = (T_DATA_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CLEAR_CYC_D  = (T_CLEAR_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLINK_CYC_D  = T_BLINK_MS * CLK_MHZ * 1000;

  // register byte offsets
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_CFG  = 8'h08;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // display memory geometry
  localparam logic [7:0] BLANK_CHAR  = 8'h20;
  localparam logic [6:0] AC_HOME     = 7'h00;
  localparam logic [6:0] ONE_END     = 7'h4f;
  localparam logic [6:0] L1_END      = 7'h27;
  localparam logic [6:0] L2_START    = 7'h40;
  localparam logic [6:0] L2_END      = 7'h67;
  localparam logic [6:0] FILL_LAST   = 7'h7f;
  localparam logic [3:0] ROW_SMALL   = 4'h7;
  localparam logic [3:0] ROW_LARGE   = 4'ha;
  localparam logic [4:0] DUTY_ONE    = 5'h08;
  localparam logic [4:0] DUTY_TWO    = 5'h10;

  // config status word field positions
  localparam int unsigned F_DISP   = 0;
  localparam int unsigned F_CUR    = 1;
  localparam int unsigned F_BLINK  = 2;
  localparam int unsigned F_INC    = 3;
  localparam int unsigned F_SOW    = 4;
  localparam int unsigned F_BUS8   = 5;
  localparam int unsigned F_LINES  = 6;
  localparam int unsigned F_FONT   = 7;
  localparam int unsigned F_CGSEL  = 8;
  localparam int unsigned F_CURVIS = 9;
  localparam int unsigned F_FULL   = 10;
  localparam int unsigned F_ROW    = 11;
  localparam int unsigned F_BLANK  = 15;
  localparam int unsigned F_DUTY   = 16;
  localparam int unsigned F_SHIFT  = 24;

  // reset values
  localparam logic RST_INC  = 1'b1;
  localparam logic RST_BUS8 = 1'b1;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } cdid_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cdid_axi_rsp_t;

  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] busy_cnt;
    logic        step_pend;
    logic        reload;
    logic        clr_act;
    logic [6:0]  clr_idx;
    logic [6:0]  ac;
    logic        cg_sel;
    logic        inc;
    logic        sow;
    logic        disp_on;
    logic        cur_on;
    logic        blink_on;
    logic        bus8;
    logic        lines2;
    logic        font10;
    logic [6:0]  shift;
    logic [31:0] blink_cnt;
    logic        blink_ph;
    logic        wr_lo;
    logic [3:0]  wr_hi;
    logic        rd_lo;
    logic [7:0]  rdbuf;
  } cdid_state_t;

endpackage

// ---- cdid_top.sv ----
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - clear fills display_ram with blank code and zeroes address_counter.
// - clear forces increment_select to increment.
// - home zeroes address_counter and display shift, ram untouched.
// - each ram data access steps address_counter by increment_select.
// - shift_on_write shifts display on display_ram writes, direction by increment_select.
// - no entry shift on display_ram reads or any glyph_ram access.
// - display_on blanks or shows display, ram kept.
// - cursor shown only with cursor_on; small font uses eighth row.
// - blink_on alternates cursor character with all dots every 0.4 s.
// - shift instruction moves cursor or display left or right.
// - display shift keeps address_counter, moves all lines.
// - bus_width_sel picks eight-bit or two-nibble transfers.
// - line_count picks one line 1/8 duty or two lines 1/16.
// - glyph address set loads six bits, selects glyph_ram.
// - display address set loads seven bits, selects display_ram.
// - display_ram address ranges follow line_count.
// - status read returns busy_flag and address_counter, no busy time.
// - data access address step lands only when busy_flag drops; cursor shift steps address_counter at once.
// - four-bit mode moves upper nibble first, then lower.
// - data accesses go to ram of latest address set.
module cdid_top
  import cdid_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_CYC_D,
  parameter int unsigned DATA_CYC  = DATA_CYC_D,
  parameter int unsigned CLEAR_CYC = CLEAR_CYC_D,
  parameter int unsigned BLINK_CYC = BLINK_CYC_D
)(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // axi4-lite slave
  input  wire cdid_axi_req_t axi_req,
  output cdid_axi_rsp_t      axi_rsp
);

  cdid_state_t s_q;
  cdid_state_t s_d;

  logic [7:0] display_ram [128];
  logic [7:0] glyph_ram   [64];

  logic       ram_we;
  logic       ram_cg;
  logic [6:0] ram_wa;
  logic [7:0] ram_wd;
  logic       busy;
  logic       byte_full;
  logic [7:0] byte_in;
  logic       cmd_go;
  logic       dat_wr_go;
  logic       dat_rd_go;
  logic       wr_fire;
  logic       ar_hs;
  logic [7:0] stat_byte;
  logic [7:0] rd_byte;
  logic       rd_done;

  // wraps per ram and per line layout
  function automatic logic [6:0] ac_step(input logic [6:0] ac, input logic up,
                                         input logic cg, input logic two);
    logic [6:0] r;
    r = ac;
    if (cg)
      r = {1'b0, up ? ac[5:0] + 6'h01 : ac[5:0] - 6'h01};
    else if (two)
      r = up ? ((ac == L1_END) ? L2_START : (ac == L2_END) ? AC_HOME : ac + 7'h01)
             : ((ac == AC_HOME) ? L2_END : (ac == L2_START) ? L1_END : ac - 7'h01);
    else
      r = up ? ((ac >= ONE_END) ? AC_HOME : ac + 7'h01)
             : ((ac == AC_HOME) ? ONE_END : ac - 7'h01);
    return r;
  endfunction

  assign busy      = (s_q.busy_cnt != 32'h0);
  assign stat_byte = {busy, s_q.ac};
  assign wr_fire   = s_q.aw_have && s_q.w_have;
  assign ar_hs     = axi_req.arvalid && !s_q.rvalid && !wr_fire;

  always_comb
  begin
    axi_rsp         = '0;
    axi_rsp.awready = !s_q.aw_have && !s_q.bvalid;
    axi_rsp.wready  = !s_q.w_have && !s_q.bvalid;
    axi_rsp.bvalid  = s_q.bvalid;
    axi_rsp.bresp   = s_q.bresp;
    // a read waits one cycle behind a pending write so both never touch the counter
    axi_rsp.arready = !s_q.rvalid && !wr_fire;
    axi_rsp.rvalid  = s_q.rvalid;
    axi_rsp.rdata   = s_q.rdata;
    axi_rsp.rresp   = s_q.rresp;
  end

  always_comb
  begin
    s_d       = s_q;
    ram_we    = 1'b0;
    ram_cg    = 1'b0;
    ram_wa    = s_q.ac;
    ram_wd    = BLANK_CHAR;
    byte_full = 1'b0;
    byte_in   = s_q.w_data;
    cmd_go    = 1'b0;
    dat_wr_go = 1'b0;
    dat_rd_go = 1'b0;
    rd_byte   = 8'h00;
    rd_done   = 1'b0;

    // read buffer follows the counter one cycle after it moves
    if (s_q.reload)
    begin
      s_d.reload = 1'b0;
      s_d.rdbuf  = s_q.cg_sel ? glyph_ram[s_q.ac[5:0]] : display_ram[s_q.ac];
    end

    // execution timer; the pending step lands as busy drops
    if (busy)
    begin
      s_d.busy_cnt = s_q.busy_cnt - 32'h1;
      if (s_q.busy_cnt == 32'h1 && s_q.step_pend)
      begin
        s_d.ac        = ac_step(s_q.ac, s_q.inc, s_q.cg_sel, s_q.lines2);
        s_d.step_pend = 1'b0;
        s_d.reload    = 1'b1;
      end
    end

    // blank fill runs inside the clear busy time
    if (s_q.clr_act)
    begin
      ram_we      = 1'b1;
      ram_wa      = s_q.clr_idx;
      ram_wd      = BLANK_CHAR;
      s_d.clr_idx = s_q.clr_idx + 7'h01;
      if (s_q.clr_idx == FILL_LAST)
        s_d.clr_act = 1'b0;
    end

    if (s_q.blink_on)
    begin
      if (s_q.blink_cnt >= BLINK_CYC - 1)
      begin
        s_d.blink_cnt = 32'h0;
        s_d.blink_ph  = !s_q.blink_ph;
      end
      else
        s_d.blink_cnt = s_q.blink_cnt + 32'h1;
    end
    else
    begin
      s_d.blink_cnt = 32'h0;
      s_d.blink_ph  = 1'b0;
    end

    // axi write side
    if (axi_req.awvalid && axi_rsp.awready)
    begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = axi_req.awaddr[7:0];
    end
    if (axi_req.wvalid && axi_rsp.wready)
    begin
      s_d.w_have  = 1'b1;
      s_d.w_data  = axi_req.wdata[7:0];
      s_d.w_lane0 = axi_req.wstrb[0];
    end
    if (s_q.bvalid && axi_req.bready)
      s_d.bvalid = 1'b0;

    if (wr_fire)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      if (s_q.aw_addr == A_CMD || s_q.aw_addr == A_DATA)
      begin
        if (s_q.w_lane0)
        begin
          if (s_q.bus8)
            byte_full = 1'b1;
          else if (!s_q.wr_lo)
          begin
            s_d.wr_hi = s_q.w_data[7:4];
            s_d.wr_lo = 1'b1;
          end
          else
          begin
            byte_in   = {s_q.wr_hi, s_q.w_data[7:4]};
            byte_full = 1'b1;
            s_d.wr_lo = 1'b0;
          end
        end
      end
      else
        s_d.bresp = RESP_SLVERR;
    end
    cmd_go    = byte_full && !busy && (s_q.aw_addr == A_CMD);
    dat_wr_go = byte_full && !busy && (s_q.aw_addr == A_DATA);

    if (cmd_go)
    begin
      s_d.busy_cnt = SHORT_CYC;
      casez (byte_in)
        8'b1???????:
        begin
          s_d.ac     = byte_in[6:0];
          s_d.cg_sel = 1'b0;
          s_d.reload = 1'b1;
        end
        8'b01??????:
        begin
          s_d.ac     = {1'b0, byte_in[5:0]};
          s_d.cg_sel = 1'b1;
          s_d.reload = 1'b1;
        end
        8'b001?????:
        begin
          s_d.bus8   = byte_in[4];
          s_d.lines2 = byte_in[3];
          s_d.font10 = byte_in[2];
        end
        8'b0001????:
        begin
          if (!byte_in[3])
          begin
            s_d.ac     = ac_step(s_q.ac, byte_in[2], s_q.cg_sel, s_q.lines2);
            s_d.reload = 1'b1;
          end
          else
            // one offset moves every line together and leaves the counter alone
            s_d.shift = byte_in[2] ? s_q.shift - 7'h01 : s_q.shift + 7'h01;
        end
        8'b00001???:
        begin
          s_d.disp_on  = byte_in[2];
          s_d.cur_on   = byte_in[1];
          s_d.blink_on = byte_in[0];
        end
        8'b000001??:
        begin
          s_d.inc = byte_in[1];
          s_d.sow = byte_in[0];
        end
        8'b0000001?:
        begin
          s_d.ac       = AC_HOME;
          s_d.cg_sel   = 1'b0;
          s_d.shift    = 7'h00;
          s_d.reload   = 1'b1;
          s_d.busy_cnt = CLEAR_CYC;
        end
        8'b00000001:
        begin
          s_d.clr_act  = 1'b1;
          s_d.clr_idx  = 7'h00;
          s_d.ac       = AC_HOME;
          s_d.cg_sel   = 1'b0;
          s_d.inc      = 1'b1;
          s_d.shift    = 7'h00;
          s_d.busy_cnt = CLEAR_CYC;
        end
        default:
          s_d.busy_cnt = SHORT_CYC;
      endcase
    end

    if (dat_wr_go)
    begin
      ram_we        = 1'b1;
      ram_cg        = s_q.cg_sel;
      ram_wa        = s_q.ac;
      ram_wd        = byte_in;
      s_d.step_pend = 1'b1;
      s_d.busy_cnt  = DATA_CYC;
      if (s_q.sow && !s_q.cg_sel)
        s_d.shift = s_q.inc ? s_q.shift + 7'h01 : s_q.shift - 7'h01;
    end

    // axi read side; status costs no busy time
    if (s_q.rvalid && axi_req.rready)
      s_d.rvalid = 1'b0;
    if (ar_hs)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = 32'h0;
      if (axi_req.araddr[7:0] == A_CMD || axi_req.araddr[7:0] == A_DATA)
      begin
        rd_byte = (axi_req.araddr[7:0] == A_CMD) ? stat_byte : s_q.rdbuf;
        if (s_q.bus8)
        begin
          s_d.rdata[7:0] = rd_byte;
          rd_done        = 1'b1;
        end
        else if (!s_q.rd_lo)
        begin
          s_d.rdata[7:4] = rd_byte[7:4];
          s_d.rd_lo      = 1'b1;
        end
        else
        begin
          s_d.rdata[7:4] = rd_byte[3:0];
          s_d.rd_lo      = 1'b0;
          rd_done        = 1'b1;
        end
      end
      else if (axi_req.araddr[7:0] == A_CFG)
      begin
        s_d.rdata[F_DISP]   = s_q.disp_on;
        s_d.rdata[F_CUR]    = s_q.cur_on;
        s_d.rdata[F_BLINK]  = s_q.blink_on;
        s_d.rdata[F_INC]    = s_q.inc;
        s_d.rdata[F_SOW]    = s_q.sow;
        s_d.rdata[F_BUS8]   = s_q.bus8;
        s_d.rdata[F_LINES]  = s_q.lines2;
        s_d.rdata[F_FONT]   = s_q.font10;
        s_d.rdata[F_CGSEL]  = s_q.cg_sel;
        s_d.rdata[F_CURVIS] = s_q.cur_on && s_q.disp_on;
        s_d.rdata[F_FULL]   = s_q.blink_on && s_q.blink_ph && s_q.disp_on;
        s_d.rdata[F_ROW+:4] = s_q.font10 ? ROW_LARGE : ROW_SMALL;
        s_d.rdata[F_BLANK]  = !s_q.disp_on;
        s_d.rdata[F_DUTY+:5] = s_q.lines2 ? DUTY_TWO : DUTY_ONE;
        s_d.rdata[F_SHIFT+:7] = s_q.shift;
      end
      else
        s_d.rresp = RESP_SLVERR;
    end
    dat_rd_go = rd_done && !busy && (axi_req.araddr[7:0] == A_DATA);
    if (dat_rd_go)
    begin
      // reads never shift; the stale buffer is why the first read can be wrong
      s_d.step_pend = 1'b1;
      s_d.busy_cnt  = DATA_CYC;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q      <= '0;
      s_q.inc  <= RST_INC;
      s_q.bus8 <= RST_BUS8;
    end
    else
      s_q <= s_d;
  end

  // ram contents need no reset; clear fills display_ram only
  always_ff @(posedge sys_clk)
  begin
    if (ram_we && !ram_cg)
      display_ram[ram_wa] <= ram_wd;
    if (ram_we && ram_cg)
      glyph_ram[ram_wa[5:0]] <= ram_wd;
  end

  a_clear_home: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_go && byte_in == 8'h01 |=> s_q.ac == AC_HOME && s_q.inc && s_q.clr_act ##128 !s_q.clr_act)
    else $error("clear did not home counter or fill ram");
  a_clear_incr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_go && byte_in == 8'h01 && !s_q.inc |=> s_q.inc)
    else $error("clear left decrement mode");
  a_home_unshift: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_go && byte_in[7:1] == 7'h01 |=> s_q.shift == 7'h00 && s_q.ac == AC_HOME)
    else $error("home did not reset shift and counter");
  a_step_late: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_q.step_pend && s_q.busy_cnt > 32'h1 |=> $stable(s_q.ac))
    else $error("counter stepped while busy");
  a_read_noshift: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dat_rd_go || (dat_wr_go && s_q.cg_sel) |=> $stable(s_q.shift))
    else $error("display shifted on read or glyph access");
  a_disp_shift_ac: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_go && byte_in[7:3] == 5'h03 |=> $stable(s_q.ac) && s_q.shift != $past(s_q.shift))
    else $error("display shift moved counter or not shifted");
  a_busy_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
    byte_full && busy && !(s_q.busy_cnt == 32'h1 && s_q.step_pend) |=> $stable(s_q.ac)
      && $stable(s_q.disp_on) && $stable(s_q.sow))
    else $error("instruction taken while busy");
  a_busy_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dat_wr_go |=> busy [*8] ##1 s_q.busy_cnt == DATA_CYC - 8)
    else $error("busy time wrong after data write");
  a_status_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ar_hs && s_q.bus8 && axi_req.araddr[7:0] == A_CMD
      |=> s_q.rvalid && s_q.rdata[7:0] == $past(stat_byte)
      && s_q.busy_cnt == (($past(s_q.busy_cnt) == 32'h0) ? 32'h0 : $past(s_q.busy_cnt) - 32'h1))
    else $error("status read wrong");
  a_shift_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dat_wr_go && s_q.sow && !s_q.cg_sel && s_q.inc |=> s_q.shift == $past(s_q.shift) + 7'h01)
    else $error("write shift missing");

endmodule

// ---- cdid_host.sv ----
`timescale 1ns/1ps
// host processor model: drives instructions and data over axi4-lite
module cdid_host
  import cdid_pkg::*;
(
  // clock
  input  wire logic          sys_clk,
  // axi4-lite master side
  output cdid_axi_req_t      axi_req,
  input  wire cdid_axi_rsp_t axi_rsp
);
  logic nib;

  initial
  begin
    axi_req = '0;
    nib = 1'b0;
  end

  // ready is looked at on the falling edge, so the handshake edge is known before it comes
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha;
    logic hw;
    logic hb;
    @(posedge sys_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= {24'h0, a};
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      ha = axi_req.awvalid && axi_rsp.awready;
      hw = axi_req.wvalid && axi_rsp.wready;
      @(posedge sys_clk);
      if (ha)
        axi_req.awvalid <= 1'b0;
      if (hw)
        axi_req.wvalid <= 1'b0;
    end while (!((ha || !axi_req.awvalid) && (hw || !axi_req.wvalid)));
    // released payload does not keep the last value
    axi_req.awaddr <= ~axi_req.awaddr;
    axi_req.wdata <= ~axi_req.wdata;
    do
    begin
      @(negedge sys_clk);
      hb = axi_rsp.bvalid;
      r = axi_rsp.bresp;
      @(posedge sys_clk);
    end while (!hb);
    axi_req.bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    @(posedge sys_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= {24'h0, a};
    axi_req.rready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      h = axi_rsp.arready;
      @(posedge sys_clk);
    end while (!h);
    axi_req.arvalid <= 1'b0;
    axi_req.araddr <= ~axi_req.araddr;
    do
    begin
      @(negedge sys_clk);
      h = axi_rsp.rvalid;
      d = axi_rsp.rdata;
      r = axi_rsp.rresp;
      @(posedge sys_clk);
    end while (!h);
    axi_req.rready <= 1'b0;
  endtask

  task bw(input logic [7:0] a, input logic [7:0] b);
    logic [1:0] r;
    if (nib)
    begin
      wr(a, {24'h0, b[7:4], 4'h0}, r);
      wr(a, {24'h0, b[3:0], 4'h0}, r);
    end
    else
      wr(a, {24'h0, b}, r);
  endtask

  task br(input logic [7:0] a, output logic [7:0] b);
    logic [31:0] v;
    logic [1:0]  r;
    if (nib)
    begin
      rd(a, v, r);
      b[7:4] = v[7:4];
      rd(a, v, r);
      b[3:0] = v[7:4];
    end
    else
    begin
      rd(a, v, r);
      b = v[7:0];
    end
  endtask

  task idle(output logic [7:0] s);
    do
      br(A_CMD, s);
    while (s[7]);
  endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import cdid_pkg::*;
  logic          sys_clk;
  logic          rst_n;
  cdid_axi_req_t axi_req;
  cdid_axi_rsp_t axi_rsp;
  int            n_mismatch;
  int            n_compared;
  int            cnt, inc, sow, dsp, cur, blk, b8, l2, fnt, ofs, gsel, i;
  logic [7:0]    dmem [128];
  logic [7:0]    gmem [64];
  logic [31:0]   lf;
  logic [31:0]   v;
  logic [1:0]    r;

  // short counts keep the clear and data waits brief
  cdid_top #(.SHORT_CYC(20), .DATA_CYC(24), .CLEAR_CYC(140), .BLINK_CYC(16)) DUT (
    .sys_clk(sys_clk),
    .rst_n  (rst_n),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp)
  );

  cdid_host u_host (
    .sys_clk(sys_clk),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task stop_test();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int adv(input int a, input int d);
    if (gsel)
      return (a + d) & 63;
    if (!l2)
      return d > 0 ? (a == 79 ? 0 : a + 1) : (a == 0 ? 79 : a - 1);
    if (d > 0)
      return a == 39 ? 64 : (a == 103 ? 0 : a + 1);
    return a == 64 ? 39 : (a == 0 ? 103 : a - 1);
  endfunction

  // blink phase bit is masked: it runs on its own timer
  function automatic logic [31:0] cfgx();
    return {1'b0, ofs[6:0], 3'h0, (l2 ? DUTY_TWO : DUTY_ONE), ~dsp[0],
            (fnt ? ROW_LARGE : ROW_SMALL), 1'b0, dsp[0] & cur[0], gsel[0], fnt[0],
            l2[0], b8[0], sow[0], inc[0], blk[0], cur[0], dsp[0]};
  endfunction

  task post();
    logic [7:0] s;
    u_host.idle(s);
    chk({24'h0, s}, {25'h0, cnt[6:0]});
    u_host.rd(A_CFG, v, r);
    chk(v & ~32'h400, cfgx());
  endtask

  task ins(input logic [7:0] b);
    u_host.bw(A_CMD, b);
    casez (b)
      8'b1???????:
      begin
        cnt = b[6:0];
        gsel = 0;
      end
      8'b01??????:
      begin
        cnt = b[5:0];
        gsel = 1;
      end
      8'b001?????:
      begin
        b8 = b[4];
        l2 = b[3];
        fnt = b[2];
      end
      8'b0001????:
        if (b[3])
          ofs = (ofs + (b[2] ? -1 : 1)) & 127;
        else
          cnt = adv(cnt, b[2] ? 1 : -1);
      8'b00001???:
      begin
        dsp = b[2];
        cur = b[1];
        blk = b[0];
      end
      8'b000001??:
      begin
        inc = b[1];
        sow = b[0];
      end
      8'b0000001?:
      begin
        cnt = 0;
        ofs = 0;
        gsel = 0;
      end
      8'b00000001:
      begin
        cnt = 0;
        ofs = 0;
        gsel = 0;
        inc = 1;
        foreach (dmem[k])
          dmem[k] = BLANK_CHAR;
      end
      default:
        cnt = cnt;
    endcase
    u_host.nib = !b8;
    post();
  endtask

  task dw(input logic [7:0] d);
    logic [7:0] s;
    u_host.bw(A_DATA, d);
    u_host.br(A_CMD, s);
    chk({24'h0, s}, {24'h0, 1'b1, cnt[6:0]});
    if (gsel)
      gmem[cnt[5:0]] = d;
    else
    begin
      dmem[cnt] = d;
      if (sow)
        ofs = (ofs + (inc ? 1 : -1)) & 127;
    end
    cnt = adv(cnt, inc ? 1 : -1);
    post();
  endtask

  task rw();
    lf = lfsr(lf);
    dw(lf[7:0]);
  endtask

  task dr();
    logic [7:0] s;
    u_host.br(A_DATA, s);
    chk({24'h0, s}, {24'h0, (gsel ? gmem[cnt[5:0]] : dmem[cnt])});
    cnt = adv(cnt, inc ? 1 : -1);
    post();
  endtask

  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    lf = 32'h3e3d33c4;
    cnt = 0;
    inc = 1;
    sow = 0;
    dsp = 0;
    cur = 0;
    blk = 0;
    b8 = 1;
    l2 = 0;
    fnt = 0;
    ofs = 0;
    gsel = 0;
    rst_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    u_host.rd(A_CFG, v, r);
    chk(v & ~32'h400, cfgx());
    ins(8'h3c);
    ins(8'h04);
    ins(8'h01);
    for (i = 8; i < 16; i++)
      ins(i[7:0]);
    ins(8'ha6);
    repeat (3) rw();
    ins(8'ha6);
    repeat (3) dr();
    ins(8'h07);
    rw();
    ins(8'h05);
    repeat (2) rw();
    ins(8'hc4);
    repeat (2) dr();
    for (i = 0; i < 4; i++)
      ins(8'h10 | (i[7:0] << 2));
    ins(8'h02);
    ins(8'ha7);
    dr();
    ins(8'h07);
    ins(8'h7e);
    repeat (3) rw();
    ins(8'h7e);
    repeat (3) dr();
    u_host.bw(A_CMD, 8'h0d);
    u_host.bw(A_CMD, 8'h08);
    dsp = 1;
    cur = 0;
    blk = 1;
    post();
    u_host.rd(8'h0c, v, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    u_host.wr(A_CFG, 32'h0, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    ins(8'h28);
    ins(8'h95);
    rw();
    ins(8'h95);
    dr();
    ins(8'h04);
    ins(8'h01);
    stop_test();
  end

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
